// ---- compare_unit.v ----
`timescale 1ns/1ns
`default_nettype none
// One compare channel: equality of counter and compare value, registered
// so the flag rises in the timer clock cycle after the match.
module compare_unit (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire tick_i,
  input wire block_i,
  input wire [15:0] counter_i,
  input wire [15:0] compare_i,
  output reg match_o
);
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      match_o <= 1'b0;
    end else begin
      // R1: compare on each tick not blocked by a counter write.
      match_o <= tick_i && !block_i && (counter_i == compare_i);
    end
  end
endmodule
`default_nettype wire

// ---- core_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input wire logic mclk_i,
  input wire logic take_i,
  input wire logic [3:0] irq_i,
  output logic [3:0] ack_o = 4'h0
);
  always @(posedge mclk_i) begin
    ack_o <= (take_i && ack_o == 4'h0) ? (irq_i & -irq_i) : 4'h0;
  end
endmodule
`default_nettype wire

// ---- pin_sync.v ----
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser; a change is accepted once stages two and
// three agree, so the first stage is read by the second only.
module pin_sync (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire pin_i,
  output reg level_o
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_o <= s3_reg;
      end
    end
  end
endmodule
`default_nettype wire

// ---- timer16_compare_capture_irq.v ----
// Notes on behaviour
// R1: Both compare registers are compared against the counter every timer tick; the code skips ticks with a counter write.
// R2: A match feeds both the interrupt flag and the channel waveform strobe.
// R3: 16-bit registers move whole bytes via one shared temporary high byte.
// R4: Capture request needs mask bit 5, global enable and capture flag.
// R5: Match B request needs mask bit 2, global enable and B flag.
// R6: Match A request needs mask bit 1, global enable and A flag.
// R7: Overflow request needs mask bit 0, global enable and overflow flag.
// R8: A capture event on the capture pin sets flag bit 5.
// R9: With capture register as top, flag bit 5 sets at top.
// R10: Capture flag clears on vector taken or on writing one.
// R11: Match B flag bit 2 sets the tick after counter equals B.
// R12: A forced B strobe never sets the match B flag.
// R13: Match B flag clears on vector taken or on writing one.
// R14: Match A flag bit 1 sets the tick after counter equals A.
// R15: A forced A strobe never sets the match A flag.
// R16: Match A flag clears on vector taken or on writing one.
// R17: Overflow sets flag bit 0 in normal and CTC; else per mode.
// R18: Overflow flag clears on vector taken or on writing one.
// R19: Flag register answers at data offset 0x36 and I/O offset 0x16.
// R20: Each capture event copies the counter into the capture register.
// R21: With capture register as top, pin captures are disabled.
// R22: Writing zero leaves flags; reserved mask and flag bits read zero.
// R23: A hardware set beats a same-cycle write-one clear.
`timescale 1ns/1ns
`default_nettype none
`include "timer16_consts.vh"
module timer16_compare_capture_irq (
  // Clock and reset.
  input wire mclk_i,
  input wire sys_rst_i,
  // Processor register port, data-space or I/O addressing.
  input wire [7:0] addr_i,
  input wire io_space_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  // Interrupt handshake with the core.
  input wire global_irq_en_i,
  input wire ack_capture_i,
  input wire ack_match_b_i,
  input wire ack_match_a_i,
  input wire ack_overflow_i,
  output reg irq_capture_o,
  output reg irq_match_b_o,
  output reg irq_match_a_o,
  output reg irq_overflow_o,
  // Counter core side.
  input wire [15:0] counter_value_i,
  input wire timer_tick_i,
  input wire counter_write_i,
  input wire overflow_event_i,
  input wire at_top_i,
  input wire [3:0] waveform_mode_field_i,
  input wire capture_edge_rising_i,
  input wire force_match_a_strobe_i,
  input wire force_match_b_strobe_i,
  input wire capture_input_pin_i,
  // Waveform unit side.
  output reg wave_strobe_a_o,
  output reg wave_strobe_b_o,
  output reg [15:0] compare_a_value_o,
  output reg [15:0] compare_b_value_o,
  output reg [15:0] capture_value_o
);

  reg [7:0] temp_high_reg;
  reg [7:0] temp_high_next;
  reg [15:0] compare_a_reg;
  reg [15:0] compare_a_next;
  reg [15:0] compare_b_reg;
  reg [15:0] compare_b_next;
  reg [15:0] capture_reg;
  reg [15:0] capture_next;
  reg [7:0] mask_reg;
  reg [7:0] mask_next;
  reg [7:0] flags_reg;
  reg [7:0] flags_next;
  reg [7:0] rdata_next;
  reg pin_prev_reg;
  reg capture_top;
  reg pin_edge;
  reg [7:0] set_vec;
  reg [7:0] clr_vec;
  reg [7:0] eff_addr;
  wire pin_level;
  wire match_a;
  wire match_b;

  // Short I/O addresses sit 0x20 below the data-space offsets.
  function [7:0] to_data_addr;
    input [7:0] a;
    input io;
    begin
      to_data_addr = io ? (a + `IO_OFFSET_SHIFT) : a;
    end
  endfunction

  function uses_capture_top;
    input [3:0] mode;
    begin
      uses_capture_top = (mode == `WGM_PWM_FC_ICR) ||
        (mode == `WGM_PWM_PC_ICR) || (mode == `WGM_CTC_ICR) ||
        (mode == `WGM_FAST_ICR);
    end
  endfunction

  pin_sync u_pin_sync (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(capture_input_pin_i),
    .level_o(pin_level)
  );

  compare_unit u_cmp_a (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .tick_i(timer_tick_i),
    .block_i(counter_write_i),
    .counter_i(counter_value_i),
    .compare_i(compare_a_reg),
    .match_o(match_a)
  );

  compare_unit u_cmp_b (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .tick_i(timer_tick_i),
    .block_i(counter_write_i),
    .counter_i(counter_value_i),
    .compare_i(compare_b_reg),
    .match_o(match_b)
  );

  always @* begin
    eff_addr = to_data_addr(addr_i, io_space_i);
    capture_top = uses_capture_top(waveform_mode_field_i);
    // R21: pin disconnected at top.
    pin_edge = !capture_top && (pin_level != pin_prev_reg) &&
      (pin_level == capture_edge_rising_i);
    set_vec = 8'h00;
    // R8: pin capture sets flag.
    set_vec[`BIT_CAPTURE] = pin_edge ||
      // R9: top reached sets flag.
      (capture_top && at_top_i);
    // R11: registered B match.
    set_vec[`BIT_MATCH_B] = match_b;
    // R14: registered A match.
    set_vec[`BIT_MATCH_A] = match_a;
    // R17: overflow event input sets flag, mode not used here.
    set_vec[`BIT_OVERFLOW] = overflow_event_i;
    clr_vec = 8'h00;
    clr_vec[`BIT_CAPTURE] = ack_capture_i;
    clr_vec[`BIT_MATCH_B] = ack_match_b_i;
    clr_vec[`BIT_MATCH_A] = ack_match_a_i;
    clr_vec[`BIT_OVERFLOW] = ack_overflow_i;
    // R19: flag register decode.
    if (wr_i && eff_addr == `ADDR_IRQ_FLAGS) begin
      // R22: zeros leave flags.
      clr_vec = clr_vec | wdata_i;
    end
    // R10: capture flag clearing.
    // R13: match B flag clearing.
    // R16: match A flag clearing.
    // R18: overflow flag clearing.
    // R23: set beats clear.
    flags_next = ((flags_reg & ~clr_vec) | set_vec) & `FLAG_MASK;

    mask_next = mask_reg;
    temp_high_next = temp_high_reg;
    compare_a_next = compare_a_reg;
    compare_b_next = compare_b_reg;
    capture_next = capture_reg;
    // R20: copy counter on capture.
    if (pin_edge) begin
      capture_next = counter_value_i;
    end
    if (wr_i) begin
      case (eff_addr)
        `ADDR_IRQ_MASK: begin
          mask_next = wdata_i & `FLAG_MASK;
        end
        // R3: high byte into shared temp.
        `ADDR_CAP_HIGH, `ADDR_CMP_A_HIGH, `ADDR_CMP_B_HIGH: begin
          temp_high_next = wdata_i;
        end
        `ADDR_CAP_LOW: begin
          capture_next = {temp_high_reg, wdata_i};
        end
        `ADDR_CMP_A_LOW: begin
          compare_a_next = {temp_high_reg, wdata_i};
        end
        `ADDR_CMP_B_LOW: begin
          compare_b_next = {temp_high_reg, wdata_i};
        end
        default: begin
          temp_high_next = temp_high_reg;
        end
      endcase
    end

    rdata_next = `RST_BYTE;
    if (rd_i) begin
      case (eff_addr)
        `ADDR_IRQ_FLAGS: rdata_next = flags_reg;
        `ADDR_IRQ_MASK: rdata_next = mask_reg;
        `ADDR_CAP_HIGH: rdata_next = temp_high_reg;
        `ADDR_CAP_LOW: rdata_next = capture_reg[7:0];
        `ADDR_CMP_A_LOW: rdata_next = compare_a_reg[7:0];
        `ADDR_CMP_A_HIGH: rdata_next = compare_a_reg[15:8];
        `ADDR_CMP_B_LOW: rdata_next = compare_b_reg[7:0];
        `ADDR_CMP_B_HIGH: rdata_next = compare_b_reg[15:8];
        default: rdata_next = `RST_BYTE;
      endcase
    end
    // R3: capture low-byte read latches high byte into temp.
    if (rd_i && eff_addr == `ADDR_CAP_LOW) begin
      temp_high_next = capture_reg[15:8];
    end
  end

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      temp_high_reg <= `RST_BYTE;
      compare_a_reg <= `RST_WORD;
      compare_b_reg <= `RST_WORD;
      capture_reg <= `RST_WORD;
      mask_reg <= `RST_BYTE;
      flags_reg <= `RST_BYTE;
      pin_prev_reg <= 1'b0;
      rdata_o <= `RST_BYTE;
      irq_capture_o <= 1'b0;
      irq_match_b_o <= 1'b0;
      irq_match_a_o <= 1'b0;
      irq_overflow_o <= 1'b0;
      wave_strobe_a_o <= 1'b0;
      wave_strobe_b_o <= 1'b0;
      compare_a_value_o <= `RST_WORD;
      compare_b_value_o <= `RST_WORD;
      capture_value_o <= `RST_WORD;
    end else begin
      temp_high_reg <= temp_high_next;
      compare_a_reg <= compare_a_next;
      compare_b_reg <= compare_b_next;
      capture_reg <= capture_next;
      mask_reg <= mask_next;
      flags_reg <= flags_next;
      pin_prev_reg <= pin_level;
      rdata_o <= rdata_next;
      // R4: capture request gating.
      irq_capture_o <= mask_next[`BIT_CAPTURE] && global_irq_en_i &&
        flags_next[`BIT_CAPTURE];
      // R5: match B request gating.
      irq_match_b_o <= mask_next[`BIT_MATCH_B] && global_irq_en_i &&
        flags_next[`BIT_MATCH_B];
      // R6: match A request gating.
      irq_match_a_o <= mask_next[`BIT_MATCH_A] && global_irq_en_i &&
        flags_next[`BIT_MATCH_A];
      // R7: overflow request gating.
      irq_overflow_o <= mask_next[`BIT_OVERFLOW] && global_irq_en_i &&
        flags_next[`BIT_OVERFLOW];
      // R2: match also drives waveform.
      // R15: forced A bypasses flag.
      wave_strobe_a_o <= match_a || force_match_a_strobe_i;
      // R12: forced B bypasses flag.
      wave_strobe_b_o <= match_b || force_match_b_strobe_i;
      compare_a_value_o <= compare_a_next;
      compare_b_value_o <= compare_b_next;
      capture_value_o <= capture_next;
    end
  end

endmodule
`default_nettype wire

// ---- timer16_compare_capture_irq_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module timer16_compare_capture_irq_bench;
  typedef struct packed {logic r; logic io; logic [7:0] a; logic [7:0] d;} row_t;
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, io = 1'b0, wr = 1'b0, rd = 1'b0;
  logic glb = 1'b0, tick = 1'b0, cwr = 1'b0, ovf = 1'b0, top = 1'b0;
  logic fa = 1'b0, fb = 1'b0, pin = 1'b0, take = 1'b0, sa, sb;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
  logic [15:0] cnt = 16'h0000, cmp_a, cmp_b, cap;
  logic [3:0] mode = 4'h0, irq, ack;
  int fails = 0, check_count = 0, i;
  row_t rows[] = '{'{1,0,8'h36,8'h00}, '{1,0,8'h6F,8'h00}, '{1,0,8'h87,8'h00},
    '{1,0,8'h88,8'h00}, '{1,0,8'h8B,8'h00}, '{0,0,8'h6F,8'hFF},
    '{1,0,8'h6F,8'h27}, '{0,0,8'h89,8'h12}, '{0,0,8'h88,8'h34},
    '{1,0,8'h88,8'h34}, '{1,0,8'h89,8'h12}, '{0,0,8'h8B,8'hAB},
    '{0,0,8'h8A,8'hCD}, '{1,0,8'h8B,8'hAB}, '{1,0,8'h8A,8'hCD},
    '{0,0,8'h50,8'hFF}, '{1,0,8'h50,8'h00}, '{1,1,8'h16,8'h00}};
  timer16_compare_capture_irq i_timer16_compare_capture_irq (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .io_space_i(io),
    .wr_i(wr), .rd_i(rd), .wdata_i(wd), .rdata_o(rdata),
    .global_irq_en_i(glb), .ack_capture_i(ack[3]), .ack_match_b_i(ack[2]),
    .ack_match_a_i(ack[1]), .ack_overflow_i(ack[0]),
    .irq_capture_o(irq[3]), .irq_match_b_o(irq[2]),
    .irq_match_a_o(irq[1]), .irq_overflow_o(irq[0]),
    .counter_value_i(cnt), .timer_tick_i(tick), .counter_write_i(cwr),
    .overflow_event_i(ovf), .at_top_i(top), .waveform_mode_field_i(mode),
    .capture_edge_rising_i(1'b1), .force_match_a_strobe_i(fa),
    .force_match_b_strobe_i(fb), .capture_input_pin_i(pin),
    .wave_strobe_a_o(sa), .wave_strobe_b_o(sb), .compare_a_value_o(cmp_a),
    .compare_b_value_o(cmp_b), .capture_value_o(cap));
  core_model i_core_model (.mclk_i(mclk_i), .take_i(take), .irq_i(irq),
    .ack_o(ack));
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task bus(input logic r, input logic s, input logic [7:0] a, d);
    @(posedge mclk_i);
    wr <= !r;
    rd <= r;
    io <= s;
    addr <= a;
    wd <= d;
    @(posedge mclk_i);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task rdf(input logic [7:0] e);
    bus(1'b1, 1'b0, 8'h36, 8'h00);
    chk("flags", {8'h00, e}, {8'h00, rdata});
  endtask
  task summarize;
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    foreach (rows[k]) begin
      bus(rows[k].r, rows[k].io, rows[k].a, rows[k].d);
      if (rows[k].r) chk("rdata", {8'h00, rows[k].d}, {8'h00, rdata});
    end
    chk("compare_b", 16'hABCD, cmp_b);
    chk("compare_a", 16'h1234, cmp_a);
    bus(1'b0, 1'b0, 8'h6F, 8'h27);
    @(posedge mclk_i);
    cnt <= 16'h1234;
    tick <= 1'b1;
    cwr <= 1'b1;
    glb <= 1'b1;
    @(posedge mclk_i);
    tick <= 1'b0;
    cwr <= 1'b0;
    rdf(8'h00);
    @(posedge mclk_i);
    tick <= 1'b1;
    @(posedge mclk_i);
    tick <= 1'b0;
    rdf(8'h02);
    chk("irq", 16'h0002, {12'h000, irq});
    bus(1'b0, 1'b0, 8'h36, 8'hFD);
    rdf(8'h02);
    bus(1'b0, 1'b1, 8'h16, 8'h02);
    rdf(8'h00);
    @(posedge mclk_i);
    fa <= 1'b1;
    fb <= 1'b1;
    glb <= 1'b0;
    @(posedge mclk_i);
    fa <= 1'b0;
    fb <= 1'b0;
    ovf <= 1'b1;
    #1;
    chk("strobes", 16'h0003, {14'h0000, sa, sb});
    @(posedge mclk_i);
    ovf <= 1'b0;
    rdf(8'h01);
    chk("irq", 16'h0000, {12'h000, irq});
    @(posedge mclk_i);
    glb <= 1'b1;
    take <= 1'b1;
    for (i = 0; i < 20 && ack[0] !== 1'b1; i++) begin
      @(posedge mclk_i);
      #1;
    end
    if (i == 20) begin
      fails++;
      summarize;
    end
    rdf(8'h00);
    take <= 1'b0;
    ovf <= 1'b1;
    wr <= 1'b1;
    addr <= 8'h36;
    wd <= 8'h01;
    @(posedge mclk_i);
    ovf <= 1'b0;
    wr <= 1'b0;
    rdf(8'h01);
    @(posedge mclk_i);
    cnt <= 16'h0555;
    pin <= 1'b1;
    for (i = 0; i < 20 && cap !== 16'h0555; i++) begin
      @(posedge mclk_i);
      #1;
    end
    if (i == 20) begin
      fails++;
      summarize;
    end
    chk("capture", 16'h0555, cap);
    rdf(8'h21);
    bus(1'b1, 1'b0, 8'h86, 8'h00);
    chk("cap_low", 16'h0055, {8'h00, rdata});
    bus(1'b1, 1'b0, 8'h87, 8'h00);
    chk("cap_high", 16'h0005, {8'h00, rdata});
    bus(1'b0, 1'b0, 8'h36, 8'h21);
    @(posedge mclk_i);
    mode <= 4'h8;
    cnt <= 16'h0777;
    pin <= 1'b0;
    repeat (10) @(posedge mclk_i);
    pin <= 1'b1;
    repeat (10) @(posedge mclk_i);
    chk("capture", 16'h0555, cap);
    top <= 1'b1;
    @(posedge mclk_i);
    top <= 1'b0;
    rdf(8'h20);
    chk("irq", 16'h0008, {12'h000, irq});
    bus(1'b0, 1'b0, 8'h6F, 8'h00);
    chk("irq", 16'h0000, {12'h000, irq});
    // A second reset in mid-run must drop the pending capture flag.
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rdf(8'h00);
    chk("compare_a", 16'h0000, cmp_a);
    summarize;
  end
endmodule
`default_nettype wire

// ---- timer16_consts.vh ----
`ifndef TIMER16_CONSTS_VH
`define TIMER16_CONSTS_VH

// Data-space offsets of the timer registers.
`define ADDR_IRQ_FLAGS 8'h36
`define IO_OFFSET_SHIFT 8'h20
`define ADDR_IRQ_MASK 8'h6F
`define ADDR_CAP_LOW 8'h86
`define ADDR_CAP_HIGH 8'h87
`define ADDR_CMP_A_LOW 8'h88
`define ADDR_CMP_A_HIGH 8'h89
`define ADDR_CMP_B_LOW 8'h8A
`define ADDR_CMP_B_HIGH 8'h8B

// Flag and mask bit positions.
`define BIT_CAPTURE 5
`define BIT_MATCH_B 2
`define BIT_MATCH_A 1
`define BIT_OVERFLOW 0
`define FLAG_MASK 8'h27

// Reset values.
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000

// Waveform modes; the four ICR ones count up to the capture register.
`define WGM_PWM_FC_ICR 4'h8
`define WGM_PWM_PC_ICR 4'hA
`define WGM_CTC_ICR 4'hC
`define WGM_FAST_ICR 4'hE
`define WGM_NORMAL 4'h0
`define WGM_CTC_OCR 4'h4

`endif

// ---- timer16_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module timer16_properties (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic io_space_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic global_irq_en_i,
  input wire logic ack_overflow_i,
  input wire logic overflow_event_i,
  input wire logic irq_capture_o,
  input wire logic irq_match_b_o,
  input wire logic irq_match_a_o,
  input wire logic irq_overflow_o,
  input wire logic [15:0] counter_value_i,
  input wire logic timer_tick_i,
  input wire logic counter_write_i,
  input wire logic force_match_b_strobe_i,
  input wire logic wave_strobe_a_o,
  input wire logic wave_strobe_b_o,
  input wire logic [15:0] compare_a_value_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  sequence hi_a_wr;
    wr_i && !io_space_i && addr_i == 8'h89;
  endsequence
  sequence lo_a_wr;
    wr_i && !io_space_i && addr_i == 8'h88;
  endsequence
  chk_word_commit: assert property (
    hi_a_wr ##1 !wr_i ##1 lo_a_wr |=>
    compare_a_value_o == {$past(wdata_i, 3), $past(wdata_i)})
    else $error("compare word not committed");
  chk_cap_global: assert property (
    irq_capture_o |-> $past(global_irq_en_i))
    else $error("capture request without global enable");
  chk_b_global: assert property (
    irq_match_b_o |-> $past(global_irq_en_i))
    else $error("match b request without global enable");
  chk_a_global: assert property (
    irq_match_a_o |-> $past(global_irq_en_i))
    else $error("match a request without global enable");
  chk_ovf_global: assert property (
    irq_overflow_o |-> $past(global_irq_en_i))
    else $error("overflow request without global enable");
  chk_mask_off: assert property (
    wr_i && !io_space_i && addr_i == 8'h6F && wdata_i == 8'h00 |=>
    !(irq_capture_o || irq_match_b_o || irq_match_a_o || irq_overflow_o))
    else $error("request after mask cleared");
  chk_ack_clears: assert property (
    ack_overflow_i && !overflow_event_i |=> !irq_overflow_o)
    else $error("overflow request after vector taken");
  chk_match_strobe: assert property (
    timer_tick_i && !counter_write_i &&
    counter_value_i == compare_a_value_o |-> ##[1:2] wave_strobe_a_o)
    else $error("no waveform strobe after match");
  chk_force_b: assert property (
    force_match_b_strobe_i |=> wave_strobe_b_o)
    else $error("forced strobe not passed on");
endmodule
bind timer16_compare_capture_irq timer16_properties i_timer16_properties (.*);
`default_nettype wire
